// [design/ascp_top.sv]
// serial port, conversion sequencing, power control and result buffer of the converter
`timescale 1ns/1ps
`include "ascp_map.svh"

// single-clock result buffer with valid/ready on both sides
module ascp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ascp_top #(
  parameter int PWRUP_CYCLES = `ASCP_PWRUP_US * `ASCP_REF_MHZ
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        serial_in_pin,
  output logic             serial_out,
  output logic             serial_out_oe,
  input  wire logic        conversion_clock,
  input  wire logic        power_down_pin,
  input  wire logic [12:0] analog_sample,
  output logic [3:0]       analog_input_selector,
  output logic [3:0]       converter_mode,
  output logic             sample_hold,
  output logic             powered_down,
  output logic             eoc,
  output logic             output_ready_flag
);
  localparam int          WB = `ASCP_WORD_BITS;
  localparam logic [3:0]  LAST_BIT = 4'(`ASCP_WORD_BITS - 1);
  localparam logic [16:0] PWRUP_LAST = 17'(PWRUP_CYCLES - 1);
  localparam logic [16:0] ACQ_LAST = 17'(`ASCP_ACQ_CONVERSION_CLOCK - 1);
  localparam logic [16:0] CONV_LAST = 17'(`ASCP_CONV_CONVERSION_CLOCK - 1);

  // ---------------- link side, on the shift clock ----------------
  // select high clears the frame counters; the clock stands still between frames
  wire link_clr = cs_n | ~rstn;

  logic [`ASCP_ADDR_BITS-1:0] in_shift;
  logic [3:0]                 in_cnt;
  ascp_pkg::ascp_addr_s       frame_word;
  logic                       frame_tgl;
  logic [3:0]                 out_idx;
  logic                       done_tgl;

  wire [`ASCP_ADDR_BITS-1:0] next_in_shift = {in_shift[`ASCP_ADDR_BITS-2:0], serial_in_pin};
  wire                       in_last       = (in_cnt == LAST_BIT);
  wire                       out_last      = (out_idx == LAST_BIT);

  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      in_cnt <= 4'h0;
    end else begin
      in_cnt <= in_last ? 4'h0 : in_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      in_shift <= next_in_shift;
    end
  end

  // the word is written on the same edge as the toggle and then held for at least a full frame, so it
  // is stable whenever the core domain samples it
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      frame_word <= `ASCP_ADDR_RESET;
      frame_tgl  <= 1'b0;
    end else if (!cs_n && in_last) begin
      frame_word <= next_in_shift;
      frame_tgl  <= ~frame_tgl;
    end
  end

  // a new frame after select falls restarts at bit zero
  always_ff @(negedge sclk or posedge link_clr) begin
    if (link_clr) begin
      out_idx <= 4'h0;
    end else begin
      out_idx <= out_last ? 4'h0 : out_idx + 4'h1;
    end
  end

  always_ff @(negedge sclk or negedge rstn) begin
    if (!rstn) begin
      done_tgl <= 1'b0;
    end else if (!cs_n && out_last) begin
      done_tgl <= ~done_tgl;
    end
  end

  // ---------------- core side, on ref_clk ----------------
  ascp_pkg::ascp_result_s out_word;
  ascp_pkg::ascp_addr_s   addr;
  ascp_pkg::ascp_state_e  state;
  ascp_pkg::ascp_state_e  next_state;

  // msb first; after the wrap bit zero shows the newest word as soon as it loads
  wire [3:0] msb_idx = LAST_BIT - out_idx;
  assign serial_out    = out_word.bits[msb_idx];
  assign serial_out_oe = ~cs_n;

  logic pd_s1;
  logic pd_s2;
  logic conversion_clock_s1;
  logic conversion_clock_s2;
  logic conversion_clock_s3;
  logic frm_s1;
  logic frm_s2;
  logic frm_s3;
  logic dn_s1;
  logic dn_s2;
  logic dn_s3;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pd_s1   <= 1'b1;
      pd_s2   <= 1'b1;
      conversion_clock_s1 <= 1'b0;
      conversion_clock_s2 <= 1'b0;
      conversion_clock_s3 <= 1'b0;
      frm_s1  <= 1'b0;
      frm_s2  <= 1'b0;
      frm_s3  <= 1'b0;
      dn_s1   <= 1'b0;
      dn_s2   <= 1'b0;
      dn_s3   <= 1'b0;
    end else begin
      pd_s1   <= power_down_pin;
      pd_s2   <= pd_s1;
      conversion_clock_s1 <= conversion_clock;
      conversion_clock_s2 <= conversion_clock_s1;
      conversion_clock_s3 <= conversion_clock_s2;
      frm_s1  <= frame_tgl;
      frm_s2  <= frm_s1;
      frm_s3  <= frm_s2;
      dn_s1   <= done_tgl;
      dn_s2   <= dn_s1;
      dn_s3   <= dn_s2;
    end
  end

  wire conversion_clock_rise  = conversion_clock_s2 & ~conversion_clock_s3;
  wire frame_done = frm_s2 ^ frm_s3;
  wire shift_done = dn_s2 ^ dn_s3;

  logic [16:0] cnt;
  logic        frame_pend;

  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [12:0] fifo_out_data;

  wire acq_end   = (state == ascp_pkg::ST_ACQ) && conversion_clock_rise && (cnt == ACQ_LAST);
  wire conv_end  = (state == ascp_pkg::ST_CONV) && conversion_clock_rise && (cnt == CONV_LAST);
  wire pwrup_end = (state == ascp_pkg::ST_PWRUP) && (cnt == PWRUP_LAST);
  // a full buffer holds off the next conversion instead of dropping a result
  wire start     = (state == ascp_pkg::ST_IDLE) && frame_pend && fifo_in_ready;
  wire load_out  = output_ready_flag && fifo_out_valid;

  always_comb begin
    next_state = state;
    case (state)
      ascp_pkg::ST_PDN: begin
        if (!pd_s2) begin
          next_state = ascp_pkg::ST_PWRUP;
        end
      end
      ascp_pkg::ST_PWRUP: begin
        if (pd_s2) begin
          next_state = ascp_pkg::ST_PDN;
        end else if (pwrup_end) begin
          next_state = ascp_pkg::ST_IDLE;
        end
      end
      ascp_pkg::ST_IDLE: begin
        if (pd_s2) begin
          next_state = ascp_pkg::ST_PDN;
        end else if (start) begin
          next_state = ascp_pkg::ST_ACQ;
        end
      end
      ascp_pkg::ST_ACQ: begin
        if (pd_s2) begin
          next_state = ascp_pkg::ST_PDN;
        end else if (acq_end) begin
          next_state = ascp_pkg::ST_CONV;
        end
      end
      ascp_pkg::ST_CONV: begin
        if (pd_s2) begin
          next_state = ascp_pkg::ST_PDN;
        end else if (conv_end) begin
          next_state = ascp_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ascp_pkg::ST_PDN;
      end
    endcase
  end

  wire state_chg = (next_state != state);
  wire cnt_step  = (state == ascp_pkg::ST_PWRUP) ||
                   (((state == ascp_pkg::ST_ACQ) || (state == ascp_pkg::ST_CONV)) && conversion_clock_rise);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= ascp_pkg::ST_PWRUP;
      cnt   <= 17'h0;
    end else begin
      state <= next_state;
      if (state_chg) begin
        cnt <= 17'h0;
      end else if (cnt_step) begin
        cnt <= cnt + 17'h1;
      end
    end
  end

  // a frame seen while busy is kept and starts the next conversion
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      frame_pend <= 1'b0;
    end else if (frame_done) begin
      frame_pend <= 1'b1;
    end else if (start) begin
      frame_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      addr <= `ASCP_ADDR_RESET;
    end else if (frame_done) begin
      addr <= frame_word;
    end
  end

  assign analog_input_selector = addr.chan;
  assign converter_mode        = addr.mode;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sample_hold  <= 1'b0;
      powered_down <= 1'b1;
      eoc          <= 1'b0;
    end else begin
      sample_hold  <= (next_state == ascp_pkg::ST_ACQ);
      powered_down <= (next_state == ascp_pkg::ST_PDN);
      eoc          <= (next_state == ascp_pkg::ST_IDLE);
    end
  end

  ascp_fifo #(
    .WIDTH (WB),
    .DEPTH (`ASCP_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_data   (analog_sample),
    .in_valid  (conv_end),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (output_ready_flag)
  );

  // the shift-out word changes only after the shift-out bit counter next wraps at the last bit with select low, even mid-frame
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      out_word          <= '0;
      output_ready_flag <= 1'b1;
    end else if (load_out) begin
      out_word          <= fifo_out_data;
      output_ready_flag <= 1'b0;
    end else if (shift_done) begin
      output_ready_flag <= 1'b1;
    end
  end
endmodule

// [design/ascp_map.svh]
// widths, field positions, reset values and timing counts of the serial converter control
`ifndef ASCP_MAP_SVH
`define ASCP_MAP_SVH
`define ASCP_WORD_BITS   13
`define ASCP_ADDR_BITS   8
`define ASCP_CHAN_LSB    0
`define ASCP_CHAN_BITS   4
`define ASCP_MODE_LSB    4
`define ASCP_MODE_BITS   4
`define ASCP_ACQ_CONVERSION_CLOCK    10
`define ASCP_CONV_CONVERSION_CLOCK   16
`define ASCP_PWRUP_US    700
`define ASCP_REF_MHZ     100
`define ASCP_FIFO_DEPTH  32
`define ASCP_ADDR_RESET  8'h00
`endif

// [design/ascp_pkg.sv]
// types shared by the serial converter control
package ascp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ACQ   = 3'h1,
    ST_CONV  = 3'h3,
    ST_PDN   = 3'h2,
    ST_PWRUP = 3'h6
  } ascp_state_e;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] chan;
  } ascp_addr_s;

  typedef struct packed {
    logic [12:0] bits;
  } ascp_result_s;
endpackage

// [dv/ascp_props.sv]
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module ascp_props #(
  parameter int PWRUP_CYCLES = 70000
) (
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       serial_in_pin,
  input wire logic       serial_out_oe,
  input wire logic       conversion_clock,
  input wire logic       power_down_pin,
  input wire logic [3:0] analog_input_selector,
  input wire logic [3:0] converter_mode,
  input wire logic       sample_hold,
  input wire logic       powered_down,
  input wire logic       eoc,
  input wire logic       output_ready_flag
);
  // slack covers one full acquisition plus conversion at the bench rate
  localparam int PW_MAX = PWRUP_CYCLES + 250;
  logic       sclk_q;
  logic       conversion_clock_q;
  logic [3:0] fcnt;
  logic [3:0] rcnt;
  logic [6:0] sreg;
  logic [7:0] cap;
  logic [4:0] hcnt;
  int         wcnt;
  wire        s_rise = sclk & !sclk_q;
  wire        s_fall = !sclk & sclk_q;
  wire        c_rise = conversion_clock & !conversion_clock_q;
  always_ff @(posedge ref_clk) begin
    sclk_q <= sclk;
    conversion_clock_q <= conversion_clock;
    hcnt   <= !sample_hold ? 5'h00 : hcnt + 5'(c_rise);
    wcnt   <= (!rstn || eoc || powered_down) ? 0 : wcnt + 1;
  end
  always_ff @(posedge ref_clk) begin
    if (cs_n) begin
      fcnt <= 4'h0;
      rcnt <= 4'h0;
    end else begin
      if (s_fall) fcnt <= (fcnt == 4'hc) ? 4'h0 : fcnt + 4'h1;
      if (s_rise) rcnt <= (rcnt == 4'hc) ? 4'h0 : rcnt + 4'h1;
      if (s_rise) sreg <= {sreg[5:0], serial_in_pin};
      if (s_rise && rcnt == 4'hc) cap <= {sreg, serial_in_pin};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_oe; serial_out_oe == !cs_n; endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
  property p_pd; $rose(power_down_pin) |-> ##[1:5] (powered_down && !eoc); endproperty
  a_pd: assert property (p_pd) else $error("no power down");
  property p_busy; (powered_down || sample_hold) |-> !eoc; endproperty
  a_busy: assert property (p_busy) else $error("done flag high while busy");
  property p_acq; $fell(sample_hold) |-> hcnt inside {[9:11]}; endproperty
  a_acq: assert property (p_acq) else $error("acquisition length wrong");
  property p_pwrup; wcnt <= PW_MAX; endproperty
  a_pwrup: assert property (p_pwrup) else $error("power up too slow");
  property p_rdy; (s_fall && !cs_n && fcnt == 4'hc) |-> ##[1:8] output_ready_flag; endproperty
  a_rdy: assert property (p_rdy) else $error("ready flag did not rise");
  property p_low;
    (s_fall && !cs_n && fcnt < 4'hc && !output_ready_flag) |=> !output_ready_flag;
  endproperty
  a_low: assert property (p_low) else $error("ready flag rose mid word");
  property p_addr;
    (s_rise && !cs_n && rcnt == 4'hc) |-> ##7 ({converter_mode, analog_input_selector} == cap);
  endproperty
  a_addr: assert property (p_addr) else $error("address word wrong");
endmodule
bind ascp_top ascp_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_props (
  .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in_pin(serial_in_pin),
  .serial_out_oe(serial_out_oe), .conversion_clock(conversion_clock),
  .power_down_pin(power_down_pin), .analog_input_selector(analog_input_selector),
  .converter_mode(converter_mode), .sample_hold(sample_hold), .powered_down(powered_down),
  .eoc(eoc), .output_ready_flag(output_ready_flag));

// [dv/ascp_host.sv]
// host serial master model
`timescale 1ns/1ps
module ascp_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic frame(input logic [12:0] word, input int n, input bit hold,
                       output logic [12:0] rd);
    int i;
    rd = 13'h0000;
    #3;
    if (cs_n) begin
      cs_n = 1'b0;
      #40;
    end
    for (i = 0; i < n; i++) begin
      sdi = word[12-i];
      #40;
      rd[12-i] = sdo;
      sclk = 1'b1;
      #40;
      sclk = 1'b0;
    end
    // data line no longer meaningful, so it is flipped rather than held
    sdi = ~sdi;
    // select rises half a period after the last falling edge, never together with it,
    // so the device still sees select low when that edge reports the word shifted out
    #40;
    if (!hold) cs_n = 1'b1;
  endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the converter control
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        conversion_clock = 1'b0;
  logic        power_down_pin = 1'b0;
  logic [12:0] analog_sample = 13'h0000;
  logic        sclk, cs_n, serial_in_pin, serial_out, serial_out_oe;
  logic [3:0]  sel, mode;
  logic        sample_hold, powered_down, eoc, output_ready_flag;
  int          err_count = 0;
  int          samples_checked = 0;
  logic [12:0] exp_q[$];
  logic [7:0]  cur_addr = 8'h00;
  int          i, k;
  // a released line reads as the inverse of the last bit, so a wrong enable corrupts the word
  wire         sdo_line = serial_out_oe ? serial_out : ~serial_out;
  always #5 ref_clk = ~ref_clk;
  always #33 conversion_clock = ~conversion_clock;
  ascp_top #(.PWRUP_CYCLES(50)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .serial_in_pin(serial_in_pin),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .conversion_clock(conversion_clock),
    .power_down_pin(power_down_pin), .analog_sample(analog_sample),
    .analog_input_selector(sel), .converter_mode(mode), .sample_hold(sample_hold),
    .powered_down(powered_down), .eoc(eoc), .output_ready_flag(output_ready_flag));
  ascp_host host (.sclk(sclk), .cs_n(cs_n), .sdi(serial_in_pin), .sdo(sdo_line));
  task automatic check(input logic [12:0] seen, input logic [12:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_eoc(input int lim);
    int n;
    n = 0;
    while (eoc !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({12'h000, n < lim}, 13'h0001);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic run(input int n, input bit hold);
    logic [7:0]  addr;
    logic [12:0] smp;
    logic [12:0] rd;
    addr = 8'($urandom);
    smp  = 13'($urandom);
    @(posedge ref_clk);
    analog_sample <= smp;
    host.frame({5'($urandom), addr}, n, hold, rd);
    if (n == 13) begin
      check(rd, exp_q.pop_front());
      exp_q.push_back(smp);
      cur_addr = addr;
    end
    repeat (8) @(posedge ref_clk);
    check({5'h00, mode, sel}, {5'h00, cur_addr});
    wait_eoc(400);
  endtask
  initial begin
    k = $urandom(30153);
    exp_q.push_back(13'h0000);
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({12'h000, eoc}, 13'h0000);
    wait_eoc(70);
    // frames 3 and 4 leave select low; frame 6 stops short and must be dropped
    for (i = 0; i < 10; i++) run((i == 6) ? 7 : 13, (i > 2 && i < 5));
    @(posedge ref_clk);
    power_down_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check({11'h000, powered_down, eoc}, 13'h0002);
    power_down_pin <= 1'b0;
    wait_eoc(58);
    final_report();
  end
  // about seven times the expected run length
  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule
